/* core/fptt_core.sv */
// Added by the designer: the APB register port and the register addresses.
`timescale 1ns/1ps
// How it works
// - True predicate: conditional trap, PC past instruction
// - False predicate: nothing happens, continue
// - Trap operand passed through uninterpreted
// - Predicate picks one of 32 tests
// - Unordered flag set on NaN with nonaware test
// - Unordered flag also sets accrued invalid
// - Form 010 word, 011 long, 100 none
// - Long operand high word first
// - Unordered exception taken before the instruction
// - Unordered exception repeats until cause cleared
// - Test converts source, sets condition, no write
// - Test condition bits from operand class
// - NaN sets NaN bit, signaling sets flag
// - Test clears listed exception bits
// - Memory source only data modes allowed
// - Select bit picks register or memory source
// - Source field is format or register
// - Packed on later variant: unimplemented type
// - Test ignores nonzero destination field
// - Power of two written to destination
// - Power clears listed bits, packed inexact input
// - Identifier field selects this coprocessor
// - Same source and destination register allowed
module fptt_core #(
	parameter logic [2:0] CP_ID  = fptt_pkg::FP_ID_DEF,
	parameter int         ADDR_W = 8
) (
	// Clock and reset
	input  wire logic              clock,
	input  wire logic              rst_n,
	// APB slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	// Exception request to the integer processor
	output fptt_pkg::fptt_exc_type exc
);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Class bits {N, Z, I, NaN} of a single value
	function automatic logic [3:0] cc_of(input logic [31:0] x);
		logic nan;
		logic inf;
		logic zro;
		nan = (x[30:23] == 8'hFF) && (x[22:0] != 23'h0);
		inf = (x[30:23] == 8'hFF) && (x[22:0] == 23'h0);
		zro = (x[30:0] == 31'h0);
		return {x[31] & ~nan, zro, inf, nan};
	endfunction : cc_of

	// Integer to single, truncating
	function automatic logic [31:0] int2sgl(input logic [31:0] v);
		logic [31:0] a;
		logic [31:0] sh;
		logic [4:0]  msb;
		a = v[31] ? (~v + 32'h1) : v;
		msb = 5'h0;
		for (int i = 0; i < 32; i++) begin
			if (a[i])
				msb = i[4:0];
		end
		sh = a << (5'd31 - msb);
		if (a == 32'h0)
			return 32'h0;
		return {v[31], 8'(msb) + fptt_pkg::SGL_BIAS, sh[30:8]};
	endfunction : int2sgl

	// Result {overflow_flag, underflow_flag, inexact_result_flag, signaling_nan_flag, value}; 2^frac taken as 1+frac
	function automatic logic [35:0] pow2(input logic [31:0] x);
		logic [3:0]         c;
		logic signed [9:0]  e;
		logic signed [40:0] fx;
		logic signed [17:0] n;
		logic [23:0]        sig;
		c = cc_of(x);
		sig = {1'b1, x[22:0]};
		e = $signed({2'b00, x[30:23]}) - 10'sd127;
		if (c[0])
			return {3'b000, ~x[22], x[31:23], 1'b1, x[21:0]};
		if (c[2])
			return {4'h0, fptt_pkg::SGL_ONE};
		if (c[1])
			return x[31] ? 36'h0 : {4'h0, fptt_pkg::SGL_PINF};
		if (e >= 10'sd7)
			return x[31] ? {4'h6, 32'h0} : {4'hA, fptt_pkg::SGL_PINF};
		if (e >= 10'sd0)
			fx = 41'(sig) << $unsigned(e);
		else
			fx = 41'(sig) >> $unsigned(-e);
		fx = x[31] ? -fx : fx;
		n = 18'(fx >>> 23);
		if (n <= -18'sd127)
			return {4'h6, 32'h0};
		return {2'b00, fx[22:0] != 23'h0, 2'b00, 8'(n + 18'sd127), fx[22:0]};
	endfunction : pow2

	// Fold the exception byte into the accrued byte
	function automatic logic [7:0] accrue(input logic [7:0] ac, input logic [7:0] ex);
		logic [7:0] r;
		r = ac;
		r[7] = ac[7] | ex[7] | ex[6] | ex[5];
		r[6] = ac[6] | ex[4];
		r[5] = ac[5] | (ex[3] & ex[1]);
		r[4] = ac[4] | ex[2];
		r[3] = ac[3] | ex[1] | ex[0] | ex[4];
		return r;
	endfunction : accrue

	// ----------------------------------------
	// State
	// ----------------------------------------
	logic [15:0]                word0_ff;
	logic [15:0]                word1_ff;
	logic [31:0]                ext_ff;
	logic [31:0]                src_ff;
	logic [31:0]                ctrl_ff;
	logic [31:0]                fpsr_ff;
	logic [31:0]                tdata_ff;
	logic [5:0]                 outcome_ff;
	logic [31:0]                fpreg_ff [8];
	logic [31:0]                prdata_ff;
	logic                       pready_ff;
	logic                       pslverr_ff;
	fptt_pkg::fptt_exc_type     exc_ff;
	fptt_pkg::fptt_state_type   state_ff;

	logic [31:0]                nxt_fpsr;
	logic [31:0]                nxt_tdata;
	logic [5:0]                 nxt_outcome;
	fptt_pkg::fptt_exc_type     nxt_exc;
	logic                       fp_we;
	logic [31:0]                fp_wd;
	logic [31:0]                rd_data;
	logic                       rd_ok;
	logic [31:0]                x;
	logic [35:0]                pr;
	logic [7:0]                 ex;

	// ----------------------------------------
	// APB access
	// ----------------------------------------
	logic       setup;
	logic       wr;
	logic [7:0] a8;
	logic       go;
	assign setup = psel & ~penable & ~pready_ff;
	// Unmapped or misaligned writes are dropped, as the error answer says
	assign wr    = psel & penable & pready_ff & pwrite & rd_ok;
	assign a8    = 8'(paddr);
	assign go    = wr && a8 == fptt_pkg::OFS_CTRL && pwdata[fptt_pkg::CTRL_GO]
		&& state_ff == fptt_pkg::ST_IDLE;

	always_comb begin
		rd_ok = 1'b1;
		rd_data = 32'h0;
		if (a8 == fptt_pkg::OFS_WORD0)
			rd_data = {16'h0, word0_ff};
		else if (a8 == fptt_pkg::OFS_WORD1)
			rd_data = {16'h0, word1_ff};
		else if (a8 == fptt_pkg::OFS_EXT)
			rd_data = ext_ff;
		else if (a8 == fptt_pkg::OFS_SRC)
			rd_data = src_ff;
		else if (a8 == fptt_pkg::OFS_CTRL)
			rd_data = {ctrl_ff[31:1], 1'b0};
		else if (a8 == fptt_pkg::OFS_FPSR)
			rd_data = fpsr_ff;
		else if (a8 == fptt_pkg::OFS_OUTCOME)
			rd_data = {25'h0, state_ff == fptt_pkg::ST_EXEC, outcome_ff};
		else if (a8 == fptt_pkg::OFS_TDATA)
			rd_data = tdata_ff;
		else if (a8 >= fptt_pkg::OFS_FPREG && a8 <= fptt_pkg::OFS_LAST && a8[1:0] == 2'b00)
			rd_data = fpreg_ff[a8[4:2]];
		else
			rd_ok = 1'b0;
		if (paddr != ADDR_W'(a8))
			rd_ok = 1'b0;
	end

	// Zero wait states: ready in the first access cycle
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff  <= 32'h0;
		end else begin
			pready_ff  <= setup;
			pslverr_ff <= setup & ~rd_ok;
			prdata_ff  <= (setup & ~pwrite & rd_ok) ? rd_data : 32'h0;
		end
	end

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	logic       mine;
	logic       is_trap;
	logic       trap_bad;
	logic       is_arith;
	logic       arith_bad;
	logic       rm;
	logic [2:0] fmt;
	logic [2:0] ea_mode;
	logic [2:0] ea_reg;
	logic [5:0] pred;
	logic [3:0] cc;
	logic       un;
	logic       cond;
	logic       branch_unordered_flag;
	logic       packed_src;
	assign mine = word0_ff[15:12] == fptt_pkg::LINE_F && word0_ff[11:9] == CP_ID;
	assign is_trap = word0_ff[8:6] == fptt_pkg::TYPE_TRAP
		&& word0_ff[5:3] == fptt_pkg::TRAP_EA;
	assign trap_bad = word1_ff[15:6] != 10'h0 || pred[5]
		|| !(word0_ff[2:0] inside {fptt_pkg::FORM_WORD, fptt_pkg::FORM_LONG,
		fptt_pkg::FORM_NONE});
	assign pred = word1_ff[5:0];
	assign cc   = fpsr_ff[fptt_pkg::CC_N:fptt_pkg::CC_NAN];
	assign un   = cc[0];
	// Mask bits: equal, greater, less, unordered
	assign cond = (pred[0] & cc[2] & ~un) | (pred[1] & ~cc[3] & ~cc[2] & ~un)
		| (pred[2] & cc[3] & ~cc[2] & ~un) | (pred[3] & un);
	assign branch_unordered_flag = un & pred[4];
	assign rm      = word1_ff[14];
	assign fmt     = word1_ff[12:10];
	assign ea_mode = word0_ff[5:3];
	assign ea_reg  = word0_ff[2:0];
	assign packed_src = rm && fmt == fptt_pkg::FMT_P;
	assign is_arith = word0_ff[8:6] == fptt_pkg::TYPE_ARITH && !word1_ff[15]
		&& !word1_ff[13]
		&& word1_ff[6:0] inside {fptt_pkg::OP_TEST, fptt_pkg::OP_POW2};
	// Register-to-register ignores the address field entirely
	assign arith_bad = rm && (fmt == fptt_pkg::FMT_BAD || ea_mode == fptt_pkg::EA_AREG
		|| (ea_mode == fptt_pkg::EA_SPEC && ea_reg > fptt_pkg::EA_IMM)
		|| (ea_mode == fptt_pkg::EA_DREG && !(fmt inside {fptt_pkg::FMT_L,
		fptt_pkg::FMT_S, fptt_pkg::FMT_W, fptt_pkg::FMT_B})));

	// Source operand; wide formats carry a single image in the low word
	always_comb begin
		if (!rm)
			x = fpreg_ff[fmt];
		else if (fmt == fptt_pkg::FMT_L)
			x = int2sgl(src_ff);
		else if (fmt == fptt_pkg::FMT_W)
			x = int2sgl({{16{src_ff[15]}}, src_ff[15:0]});
		else if (fmt == fptt_pkg::FMT_B)
			x = int2sgl({{24{src_ff[7]}}, src_ff[7:0]});
		else
			x = src_ff;
	end
	assign pr = pow2(x);

	// ----------------------------------------
	// Execute
	// ----------------------------------------
	always_comb begin
		nxt_fpsr    = fpsr_ff;
		nxt_tdata   = tdata_ff;
		nxt_outcome = 6'h0;
		nxt_exc     = '0;
		fp_we       = 1'b0;
		fp_wd       = 32'h0;
		ex          = 8'h0;
		nxt_outcome[fptt_pkg::OUT_DONE] = 1'b1;
		if (!mine) begin
			nxt_outcome[fptt_pkg::OUT_FOREIGN] = 1'b1;
		end else if (is_trap && !trap_bad) begin
			if (branch_unordered_flag) begin
				nxt_fpsr[fptt_pkg::EX_BRANCH_UNORDERED_FLAG] = 1'b1;
				nxt_fpsr[fptt_pkg::AC_IOP]  = 1'b1;
			end
			// Stateless check, so a return without clearing NaN traps again
			if (branch_unordered_flag && ctrl_ff[fptt_pkg::CTRL_BRANCH_UNORDERED_FLAG_EN]) begin
				nxt_exc.valid    = 1'b1;
				nxt_exc.kind     = fptt_pkg::EXC_BRANCH_UNORDERED_FLAG;
				nxt_exc.pc_words = 3'h0;
				nxt_outcome[fptt_pkg::OUT_BRANCH_UNORDERED_FLAG] = 1'b1;
			end else if (cond) begin
				nxt_exc.valid = 1'b1;
				nxt_exc.kind  = fptt_pkg::EXC_TRAP;
				if (word0_ff[2:0] == fptt_pkg::FORM_WORD) begin
					nxt_exc.pc_words = 3'h3;
					nxt_exc.data = {16'h0, ext_ff[31:16]};
				end else if (word0_ff[2:0] == fptt_pkg::FORM_LONG) begin
					nxt_exc.pc_words = 3'h4;
					nxt_exc.data = ext_ff;
				end else begin
					nxt_exc.pc_words = 3'h2;
				end
				nxt_tdata = nxt_exc.data;
				nxt_outcome[fptt_pkg::OUT_TRAP] = 1'b1;
			end
		end else if (is_arith && !arith_bad) begin
			if (packed_src && ctrl_ff[fptt_pkg::CTRL_LATER]) begin
				nxt_exc.valid = 1'b1;
				nxt_exc.kind  = fptt_pkg::EXC_UNIMPL;
				nxt_outcome[fptt_pkg::OUT_UNIMPL] = 1'b1;
			end else if (word1_ff[6:0] == fptt_pkg::OP_TEST) begin
				// Destination field decoded but never used
				nxt_fpsr[fptt_pkg::CC_N:fptt_pkg::CC_NAN] = cc_of(x);
				ex[6] = cc_of(x) == 4'h1 && !x[22];
				ex[0] = packed_src & fpsr_ff[fptt_pkg::EX_INEXACT_DECIMAL_INPUT_FLAG];
				nxt_fpsr[fptt_pkg::EX_BRANCH_UNORDERED_FLAG:fptt_pkg::EX_INEXACT_DECIMAL_INPUT_FLAG] = ex;
				nxt_fpsr[7:0] = accrue(fpsr_ff[7:0], ex);
			end else begin
				fp_we = 1'b1;
				fp_wd = pr[31:0];
				ex = {1'b0, pr[32], 1'b0, pr[35], pr[34], 1'b0, pr[33], packed_src};
				nxt_fpsr[fptt_pkg::CC_N:fptt_pkg::CC_NAN] = cc_of(pr[31:0]);
				nxt_fpsr[fptt_pkg::EX_BRANCH_UNORDERED_FLAG:fptt_pkg::EX_INEXACT_DECIMAL_INPUT_FLAG] = ex;
				nxt_fpsr[7:0] = accrue(fpsr_ff[7:0], ex);
			end
		end else begin
			nxt_exc.valid = 1'b1;
			nxt_exc.kind  = fptt_pkg::EXC_ILLEGAL;
			nxt_outcome[fptt_pkg::OUT_ILLEGAL] = 1'b1;
		end
	end

	// ----------------------------------------
	// Sequencing
	// ----------------------------------------
	always_ff @(posedge clock) begin
		if (!rst_n)
			state_ff <= fptt_pkg::ST_IDLE;
		else if (go)
			state_ff <= fptt_pkg::ST_EXEC;
		else
			state_ff <= fptt_pkg::ST_IDLE;
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			outcome_ff <= 6'h0;
			tdata_ff   <= 32'h0;
			exc_ff     <= '0;
		end else begin
			exc_ff <= '0;
			if (go)
				outcome_ff <= 6'h0;
			if (state_ff == fptt_pkg::ST_EXEC) begin
				outcome_ff <= nxt_outcome;
				tdata_ff   <= nxt_tdata;
				exc_ff     <= nxt_exc;
			end
		end
	end

	// ----------------------------------------
	// Software-visible registers
	// ----------------------------------------
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			word0_ff <= 16'h0;
			word1_ff <= 16'h0;
			ext_ff   <= 32'h0;
			src_ff   <= 32'h0;
			ctrl_ff  <= fptt_pkg::RST_CTRL;
		end else if (wr) begin
			if (a8 == fptt_pkg::OFS_WORD0)
				word0_ff <= pwdata[15:0];
			else if (a8 == fptt_pkg::OFS_WORD1)
				word1_ff <= pwdata[15:0];
			else if (a8 == fptt_pkg::OFS_EXT)
				ext_ff <= pwdata;
			else if (a8 == fptt_pkg::OFS_SRC)
				src_ff <= pwdata;
			else if (a8 == fptt_pkg::OFS_CTRL)
				ctrl_ff <= {29'h0, pwdata[2:1], 1'b0};
		end
	end

	// Execution result wins over a software write in the same cycle
	always_ff @(posedge clock) begin
		if (!rst_n)
			fpsr_ff <= fptt_pkg::RST_FPSR;
		else if (state_ff == fptt_pkg::ST_EXEC)
			fpsr_ff <= nxt_fpsr;
		else if (wr && a8 == fptt_pkg::OFS_FPSR)
			fpsr_ff <= pwdata;
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			for (int i = 0; i < 8; i++)
				fpreg_ff[i] <= 32'h0;
		end else if (state_ff == fptt_pkg::ST_EXEC && fp_we) begin
			fpreg_ff[word1_ff[9:7]] <= fp_wd;
		end else if (wr && a8 >= fptt_pkg::OFS_FPREG && a8 <= fptt_pkg::OFS_LAST) begin
			fpreg_ff[a8[4:2]] <= pwdata;
		end
	end

	assign prdata  = prdata_ff;
	assign pready  = pready_ff;
	assign pslverr = pslverr_ff;
	assign exc     = exc_ff;

endmodule : fptt_core

/* pkg/fptt_pkg.sv */
package fptt_pkg;

	// ----------------------------------------
	// Register map (byte offsets)
	// ----------------------------------------
	localparam logic [7:0] OFS_WORD0   = 8'h00;
	localparam logic [7:0] OFS_WORD1   = 8'h04;
	localparam logic [7:0] OFS_EXT     = 8'h08;
	localparam logic [7:0] OFS_SRC     = 8'h0C;
	localparam logic [7:0] OFS_CTRL    = 8'h10;
	localparam logic [7:0] OFS_FPSR    = 8'h14;
	localparam logic [7:0] OFS_OUTCOME = 8'h18;
	localparam logic [7:0] OFS_TDATA   = 8'h1C;
	localparam logic [7:0] OFS_FPREG   = 8'h20;
	localparam logic [7:0] OFS_LAST    = 8'h3C;

	// ----------------------------------------
	// Field positions and reset values
	// ----------------------------------------
	localparam int CTRL_GO      = 0;
	localparam int CTRL_LATER   = 1;
	localparam int CTRL_BRANCH_UNORDERED_FLAG_EN = 2;
	localparam int CC_N         = 27;
	localparam int CC_Z         = 26;
	localparam int CC_I         = 25;
	localparam int CC_NAN       = 24;
	localparam int EX_BRANCH_UNORDERED_FLAG      = 15;
	localparam int EX_INEXACT_DECIMAL_INPUT_FLAG     = 8;
	localparam int AC_IOP       = 7;
	localparam int OUT_DONE     = 0;
	localparam int OUT_TRAP     = 1;
	localparam int OUT_BRANCH_UNORDERED_FLAG     = 2;
	localparam int OUT_UNIMPL   = 3;
	localparam int OUT_ILLEGAL  = 4;
	localparam int OUT_FOREIGN  = 5;
	localparam int OUT_BUSY     = 6;
	localparam logic [31:0] RST_CTRL = 32'h0000_0000;
	localparam logic [31:0] RST_FPSR = 32'h0000_0000;

	// ----------------------------------------
	// Operation word encodings
	// ----------------------------------------
	localparam logic [2:0] FP_ID_DEF  = 3'h1;
	localparam logic [3:0] LINE_F     = 4'hF;
	localparam logic [2:0] TYPE_TRAP  = 3'h1;
	localparam logic [2:0] TYPE_ARITH = 3'h0;
	localparam logic [2:0] TRAP_EA    = 3'h7;
	localparam logic [2:0] FORM_WORD  = 3'h2;
	localparam logic [2:0] FORM_LONG  = 3'h3;
	localparam logic [2:0] FORM_NONE  = 3'h4;
	localparam logic [6:0] OP_TEST    = 7'h3A;
	localparam logic [6:0] OP_POW2    = 7'h11;
	localparam logic [2:0] FMT_L      = 3'h0;
	localparam logic [2:0] FMT_S      = 3'h1;
	localparam logic [2:0] FMT_P      = 3'h3;
	localparam logic [2:0] FMT_W      = 3'h4;
	localparam logic [2:0] FMT_B      = 3'h6;
	localparam logic [2:0] FMT_BAD    = 3'h7;
	localparam logic [2:0] EA_DREG    = 3'h0;
	localparam logic [2:0] EA_AREG    = 3'h1;
	localparam logic [2:0] EA_SPEC    = 3'h7;
	localparam logic [2:0] EA_IMM     = 3'h4;

	// ----------------------------------------
	// Single-precision constants
	// ----------------------------------------
	localparam logic [31:0] SGL_ONE  = 32'h3F80_0000;
	localparam logic [31:0] SGL_PINF = 32'h7F80_0000;
	localparam logic [7:0]  SGL_BIAS = 8'h7F;

	typedef enum logic [2:0] {
		EXC_NONE, EXC_TRAP, EXC_BRANCH_UNORDERED_FLAG, EXC_UNIMPL, EXC_ILLEGAL
	} fptt_exc_kind_type;

	typedef enum logic {ST_IDLE, ST_EXEC} fptt_state_type;

	typedef struct packed {
		logic              valid;
		fptt_exc_kind_type kind;
		logic [2:0]        pc_words;
		logic [31:0]       data;
	} fptt_exc_type;

endpackage : fptt_pkg

/* sim/fptt_sva.sv */
`timescale 1ns/1ps
module fptt_sva #(
	parameter logic [2:0] CP_ID  = fptt_pkg::FP_ID_DEF,
	parameter int         ADDR_W = 8
) (
	// Clock and reset
	input wire logic                   clock,
	input wire logic                   rst_n,
	// APB
	input wire logic                   psel,
	input wire logic                   penable,
	input wire logic                   pwrite,
	input wire logic [ADDR_W-1:0]      paddr,
	input wire logic [31:0]            pwdata,
	input wire logic [31:0]            prdata,
	input wire logic                   pready,
	input wire logic                   pslverr,
	// Exception request
	input wire fptt_pkg::fptt_exc_type exc
);
	logic        wr;
	logic        go;
	logic [15:0] w0_ff;
	logic [31:0] ext_ff;
	logic [2:0]  nw;
	logic [31:0] ed;
	assign wr = psel && penable && pready && pwrite;
	assign go = wr && paddr == ADDR_W'(fptt_pkg::OFS_CTRL) && pwdata[fptt_pkg::CTRL_GO];
	assign nw = (w0_ff[2:0] == fptt_pkg::FORM_WORD) ? 3'h3 :
		(w0_ff[2:0] == fptt_pkg::FORM_LONG) ? 3'h4 : 3'h2;
	assign ed = (w0_ff[2:0] == fptt_pkg::FORM_WORD) ? {16'h0000, ext_ff[31:16]} :
		(w0_ff[2:0] == fptt_pkg::FORM_LONG) ? ext_ff : 32'h0000_0000;
	// Shadow of the last instruction words seen on the bus
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			w0_ff  <= 16'h0000;
			ext_ff <= 32'h0000_0000;
		end else begin
			if (wr && paddr == ADDR_W'(fptt_pkg::OFS_WORD0)) w0_ff <= pwdata[15:0];
			if (wr && paddr == ADDR_W'(fptt_pkg::OFS_EXT)) ext_ff <= pwdata;
		end
	end
	// ----
	// Properties
	// ----
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	AST_PREADY_NEXT: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	AST_ERR_WITH_READY: assert property (pslverr |-> pready)
		else $error("error without ready");
	AST_RDATA_IDLE: assert property (!pready |-> prdata == 32'h0000_0000)
		else $error("read data outside access");
	AST_EXC_PULSE: assert property ($rose(exc.valid) |=> !exc.valid)
		else $error("exception longer than one cycle");
	AST_EXC_AFTER_GO: assert property (exc.valid |-> $past(go, 2))
		else $error("exception without start two cycles before");
	AST_TRAP_WORDS: assert property (exc.valid && exc.kind == fptt_pkg::EXC_TRAP |->
		exc.pc_words == nw) else $error("trap skip length wrong");
	AST_TRAP_DATA: assert property (exc.valid && exc.kind == fptt_pkg::EXC_TRAP |->
		exc.data == ed) else $error("trap operand wrong");
	AST_TRAP_HDR: assert property (exc.valid && exc.kind == fptt_pkg::EXC_TRAP |->
		w0_ff[15:3] == {fptt_pkg::LINE_F, CP_ID, fptt_pkg::TYPE_TRAP, fptt_pkg::TRAP_EA})
		else $error("trap taken on bad first word");
	AST_OWN_ID: assert property (exc.valid |-> w0_ff[11:9] == CP_ID)
		else $error("exception for foreign coprocessor");
	AST_UNORD_PRE: assert property (exc.valid && exc.kind == fptt_pkg::EXC_BRANCH_UNORDERED_FLAG |->
		exc.pc_words == 3'h0) else $error("unordered not pre-instruction");
	AST_UNIMPL_ZERO: assert property (exc.valid && exc.kind == fptt_pkg::EXC_UNIMPL |->
		exc.pc_words == 3'h0 && exc.data == 32'h0000_0000) else $error("unimpl fields");
	cover property (exc.valid && exc.kind == fptt_pkg::EXC_TRAP);
	cover property (exc.valid && exc.kind == fptt_pkg::EXC_BRANCH_UNORDERED_FLAG);
	cover property (exc.valid && exc.kind == fptt_pkg::EXC_UNIMPL);
endmodule : fptt_sva

bind fptt_core fptt_sva #(.CP_ID(CP_ID), .ADDR_W(ADDR_W)) i_fptt_sva (.clock, .rst_n,
	.psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .exc);

/* sim/fptt_cpu_model.sv */
`timescale 1ns/1ps
module fptt_cpu_model #(
	parameter logic [31:0] PC_BASE  = 32'h0000_1000,
	parameter logic [7:0]  TRAP_VEC = 8'h07
) (
	// Clock and reset
	input wire logic                   clock,
	input wire logic                   rst_n,
	// Exception request from the coprocessor
	input wire fptt_pkg::fptt_exc_type exc,
	// Handler view
	output logic [31:0]                pc_ff,
	output logic [7:0]                 vec_ff
);
	// ----
	// Saved program counter
	// ----
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			pc_ff  <= PC_BASE;
			vec_ff <= 8'h00;
		end else if (exc.valid) begin
			if (exc.kind == fptt_pkg::EXC_TRAP) begin
				pc_ff  <= pc_ff + {28'h0, exc.pc_words, 1'b0};
				vec_ff <= TRAP_VEC;
			end else begin
				// Handler returns to the same word; cause is cleared by the bench
				vec_ff <= {5'h00, exc.kind};
			end
		end
	end
endmodule : fptt_cpu_model

/* sim/test_fptt_core.sv */
`timescale 1ns/1ps
module test_fptt_core;
	typedef struct {logic [31:0] v; logic [31:0] m; logic e;} fptt_note_type;
	logic                   clock   = 1'b0;
	logic                   rst_n   = 1'b0;
	logic                   psel    = 1'b0;
	logic                   penable = 1'b0;
	logic                   pwrite  = 1'b0;
	logic [7:0]             paddr   = 8'h00;
	logic [31:0]            pwdata  = 32'h0000_0000;
	logic [31:0]            prdata, rd, x, dat, epc, pc_ff;
	logic                   pready, pslverr;
	logic [7:0]             vec_ff;
	logic [2:0]             w;
	fptt_pkg::fptt_exc_type exc, xe;
	fptt_note_type          nt;
	fptt_note_type          rq[$];
	fptt_pkg::fptt_exc_type xq[$];
	int                     n_mismatch = 0;
	int                     checks_done = 0;
	int                     cyc = 0;
	int                     i;
	integer                 seed = 32'h0618FB57;
	logic [31:0] tv [8] = '{32'h3F80_0000, 32'hBF80_0000, 32'h0000_0000, 32'h8000_0000,
		32'h7F80_0000, 32'hFF80_0000, 32'h7FC0_0000, 32'h7F80_0001};
	logic [3:0]  tc [8] = '{4'h0, 4'h8, 4'h4, 4'hC, 4'h2, 4'hA, 4'h1, 4'h1};
	logic [31:0] pe [5] = '{32'h3F80_0000, 32'h3F80_0000, 32'h7F80_0000, 32'h0, 32'h4000_0000};
	fptt_core #(.CP_ID(fptt_pkg::FP_ID_DEF), .ADDR_W(8)) i_fptt_core (.clock, .rst_n,
		.psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .exc);
	fptt_cpu_model i_fptt_cpu_model (.clock, .rst_n, .exc, .pc_ff, .vec_ff);
	initial forever #5 clock = ~clock;
	// ----
	// Bus and check tasks
	// ----
	task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic apb(logic wn, logic [7:0] a, logic [31:0] d, output logic [31:0] q);
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= wn;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do begin
			@(posedge clock);
		end while (pready !== 1'b1);
		q = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(logic [7:0] a, logic [31:0] d);
		apb(1'b1, a, d, rd);
	endtask : wr
	task automatic rdc(logic [7:0] a, logic [31:0] v, logic [31:0] m, logic e);
		rq.push_back('{v, m, e});
		apb(1'b0, a, 32'h0, rd);
	endtask : rdc
	task automatic run(logic [15:0] w0, logic [15:0] w1, logic [31:0] ext, logic [31:0] op);
		wr(fptt_pkg::OFS_WORD0, {16'h0000, w0});
		wr(fptt_pkg::OFS_WORD1, {16'h0000, w1});
		wr(fptt_pkg::OFS_EXT, ext);
		wr(fptt_pkg::OFS_CTRL, op | 32'h0000_0001);
		do begin
			rdc(fptt_pkg::OFS_OUTCOME, 32'h0, 32'h0, 1'b0);
		end while (rd[fptt_pkg::OUT_DONE] !== 1'b1);
	endtask : run
	function automatic logic [15:0] tw0(logic [2:0] f);
		return {fptt_pkg::LINE_F, fptt_pkg::FP_ID_DEF, fptt_pkg::TYPE_TRAP, fptt_pkg::TRAP_EA, f};
	endfunction : tw0
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : report_and_stop
	// ----
	// Result watcher: oldest note against each result
	// ----
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_mismatch++;
			report_and_stop();
		end
		if (psel && penable && !pwrite && pready === 1'b1) begin
			nt = '{32'h0, 32'h0, 1'bx};
			if (rq.size() > 0) nt = rq.pop_front();
			if (nt.m != 32'h0) chk("prdata", nt.v & nt.m, prdata & nt.m);
			chk("pslverr", {31'h0, nt.e}, {31'h0, pslverr});
		end
		if (exc.valid === 1'b1) begin
			xe = xq.size() > 0 ? xq.pop_front() : '0;
			chk("exc_kind", {26'h0, xe.kind, xe.pc_words}, {26'h0, exc.kind, exc.pc_words});
			chk("exc_data", xe.data, exc.data);
		end
	end
	// ----
	// Scenarios
	// ----
	initial begin
		repeat (20) @(posedge clock);
		rst_n <= 1'b1;
		epc = 32'h0000_1000;
		rdc(fptt_pkg::OFS_CTRL, fptt_pkg::RST_CTRL, 32'hFFFF_FFFF, 1'b0);
		rdc(fptt_pkg::OFS_FPSR, fptt_pkg::RST_FPSR, 32'hFFFF_FFFF, 1'b0);
		rdc(8'h40, 32'h0, 32'hFFFF_FFFF, 1'b1);
		for (i = 0; i < 3; i++) begin
			x = $random(seed);
			w = (i == 2) ? 3'h2 : 3'(i + 3);
			dat = (i == 0) ? {16'h0000, x[31:16]} : (i == 1) ? x : 32'h0;
			xq.push_back('{1'b1, fptt_pkg::EXC_TRAP, w, dat});
			run(tw0(3'(i + 2)), 16'h000F, x, 32'h0);
			epc = epc + {28'h0, w, 1'b0};
			chk("saved_pc", epc, pc_ff);
			chk("vector", 32'h0000_0007, {24'h0, vec_ff});
			rdc(fptt_pkg::OFS_TDATA, dat, 32'hFFFF_FFFF, 1'b0);
		end
		run(tw0(fptt_pkg::FORM_NONE), 16'h0000, 32'h0, 32'h0);
		rdc(fptt_pkg::OFS_OUTCOME, 32'h1, 32'h3, 1'b0);
		for (i = 0; i < 32; i++) begin
			xq.push_back('{1'b1, fptt_pkg::EXC_ILLEGAL, 3'h0, 32'h0});
			run(tw0(fptt_pkg::FORM_NONE), 16'(i + 32), 32'h0, 32'h0);
		end
		wr(fptt_pkg::OFS_FPSR, 32'h0100_0000);
		for (i = 0; i < 2; i++) begin
			xq.push_back('{1'b1, fptt_pkg::EXC_BRANCH_UNORDERED_FLAG, 3'h0, 32'h0});
			run(tw0(fptt_pkg::FORM_NONE), 16'h0010, 32'h0, 32'h4);
			chk("saved_pc", epc, pc_ff);
			chk("vector", {29'h0, fptt_pkg::EXC_BRANCH_UNORDERED_FLAG}, {24'h0, vec_ff});
			rdc(fptt_pkg::OFS_FPSR, 32'h0100_8080, 32'hFFFF_FFF8, 1'b0);
		end
		wr(fptt_pkg::OFS_FPSR, 32'h0100_0000);
		xq.push_back('{1'b1, fptt_pkg::EXC_TRAP, 3'h2, 32'h0});
		run(tw0(fptt_pkg::FORM_NONE), 16'h000F, 32'h0, 32'h4);
		epc = epc + 32'h4;
		rdc(fptt_pkg::OFS_FPSR, 32'h0100_0000, 32'hFFFF_FFF8, 1'b0);
		wr(fptt_pkg::OFS_FPSR, 32'h0000_0000);
		run(tw0(fptt_pkg::FORM_NONE), 16'h0010, 32'h0, 32'h4);
		rdc(fptt_pkg::OFS_OUTCOME, 32'h1, 32'h7, 1'b0);
		for (i = 0; i < 8; i++) wr(8'h20 + 8'(4 * i), tv[i]);
		for (i = 0; i < 8; i++) begin
			wr(fptt_pkg::OFS_FPSR, 32'h00AB_FF00);
			run({4'hF, fptt_pkg::FP_ID_DEF, 9'h000}, {3'h0, 3'(i), 3'h5, fptt_pkg::OP_TEST},
				32'h0, 32'h0);
			rdc(fptt_pkg::OFS_FPSR, {4'h0, tc[i], 8'hAB, 1'b0, (i == 7), 14'h0},
				32'hFFFF_FF00, 1'b0);
		end
		rdc(8'h34, 32'hFF80_0000, 32'hFFFF_FFFF, 1'b0);
		xq.push_back('{1'b1, fptt_pkg::EXC_UNIMPL, 3'h0, 32'h0});
		run({4'hF, fptt_pkg::FP_ID_DEF, 6'h02, 3'h0}, {3'h2, fptt_pkg::FMT_P, 3'h0,
			fptt_pkg::OP_TEST}, 32'h0, 32'h2);
		xq.push_back('{1'b1, fptt_pkg::EXC_ILLEGAL, 3'h0, 32'h0});
		run({4'hF, fptt_pkg::FP_ID_DEF, 3'h0, fptt_pkg::EA_AREG, 3'h0}, {3'h2, fptt_pkg::FMT_L,
			3'h0, fptt_pkg::OP_TEST}, 32'h0, 32'h0);
		xq.push_back('{1'b1, fptt_pkg::EXC_ILLEGAL, 3'h0, 32'h0});
		run({4'hF, fptt_pkg::FP_ID_DEF, 9'h000}, {3'h2, 3'h5, 3'h0, fptt_pkg::OP_TEST},
			32'h0, 32'h0);
		run({4'hF, 3'h2, 9'h000}, {6'h00, 3'h0, fptt_pkg::OP_TEST}, 32'h0, 32'h0);
		rdc(fptt_pkg::OFS_OUTCOME, 32'h21, 32'h3F, 1'b0);
		for (i = 0; i < 5; i++) begin
			w = (i == 4) ? 3'h0 : 3'h7;
			wr(fptt_pkg::OFS_FPSR, 32'h00AB_FF00);
			run({4'hF, fptt_pkg::FP_ID_DEF, 9'h000}, {3'h0, (i == 4) ? 3'h0 : 3'(i + 2), w,
				fptt_pkg::OP_POW2}, 32'h0, 32'h0);
			rdc(8'h20 + {3'h0, w, 2'h0}, pe[i], 32'hFFFF_FFFF, 1'b0);
			rdc(fptt_pkg::OFS_FPSR, 32'h00AB_0000, 32'h00FF_A500, 1'b0);
		end
		w = 3'($random(seed));
		wr(fptt_pkg::OFS_SRC, {29'h0, w});
		run({4'hF, fptt_pkg::FP_ID_DEF, 9'h000}, {3'h2, fptt_pkg::FMT_L, 3'h6,
			fptt_pkg::OP_POW2}, 32'h0, 32'h0);
		wr(8'h3A, 32'h0000_0000);
		rdc(8'h38, {1'b0, fptt_pkg::SGL_BIAS + {5'h0, w}, 23'h0}, 32'hFFFF_FFFF, 1'b0);
		chk("pending_exc", 32'h0, 32'(xq.size()));
		chk("final_pc", epc, pc_ff);
		report_and_stop();
	end
endmodule : test_fptt_core
